//--- rtl/spvcr_regs.sv
// per-port vendor config register bank with default override load port
// assumes synchronous request inputs; loader port carries smbus/eeprom writes
//
// Operation
// [RULE_01] read-only lane mode in phy word bits 6:0, reset zero
// [RULE_02] read-only delta bits 31:15 reset one; bits 14:7 reserved
// [RULE_03] tx margin reset 116b; rx equaliser 86 upstream, zero downstream
// [RULE_04] mode word packs seven zeros then the strap indicators
// [RULE_05] bit 20 resets from powerdown strap; one disables refclk outputs
// [RULE_06] bits 19:16 enable each refclk output pair, reset all enabled
// [RULE_07] clock-buffer defaults overridable by strap, management bus or eeprom
// [RULE_08] capability id byte reads constant 0d
// [RULE_09] next pointer byte reads c0
// [RULE_10] subsystem vendor ident in bits 15:0, reset zero, loadable
// [RULE_11] subsystem device ident in bits 31:16, reset zero, loadable
// [RULE_12] general pin control exists only on upstream port
// [RULE_13] input bits 0,4,8 reflect current pin levels
// [RULE_14] direction bits 1,5,9: one output, reset input
// [RULE_15] output value bits 2,6,10 drive pins when output
// [RULE_16] reserved bits read zero; writes to read-only fields ignored
`timescale 1ns/100ps
`default_nettype none
`include "spvcr_defines.svh"
module spvcr_regs #(
  parameter bit UPSTREAM = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // straps
  input wire spvcr_pkg::spvcr_mode_s mode_straps_i,
  input wire logic refclk_buffer_powerdown_strap_i,
  // software register access
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // default override from management bus or eeprom loader
  input wire spvcr_pkg::spvcr_load_s load_i,
  // general purpose pins
  input wire logic [2:0] gpio_in_i,
  output logic [2:0] gpio_out_o,
  output logic [2:0] gpio_oe_o,
  // refclk control
  output logic refclk_global_disable_o,
  output logic [3:0] refclk_output_pair_en_o
);
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  logic strap_taken_ff;
  logic [6:0] lane_mode_ff;
  logic [16:0] phy_delta_ff;
  logic [15:0] tx_margin_ff;
  logic [7:0] rx_eq_ff;
  logic refclk_pd_ff;
  logic [3:0] refclk_en_ff;
  logic [15:0] vendor_ident_ff;
  logic [15:0] device_ident_ff;
  spvcr_pkg::spvcr_mode_s mode_ff;
  logic [2:0] dir_ff, outv_ff, pin_in_ff;
  wire logic ld_ok = load_i.valid;

  // loader overrides defaults; software cannot write these fields
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lane_mode_ff <= `SPVCR_RST_LANE_MODE; // [RULE_01]
      phy_delta_ff <= `SPVCR_RST_PHY_DELTA; // [RULE_02]
      tx_margin_ff <= `SPVCR_RST_TX_MARGIN; // [RULE_03]
      rx_eq_ff <= UPSTREAM ? `SPVCR_RST_RX_EQ_UP : `SPVCR_RST_RX_EQ_DOWN; // [RULE_03]
      vendor_ident_ff <= `SPVCR_RST_IDENT; // [RULE_10]
      device_ident_ff <= `SPVCR_RST_IDENT; // [RULE_11]
    end else if (ld_ok) begin
      if (load_i.offset == `SPVCR_OFF_PHY_LANE_MODE_AND_DELTA) begin
        lane_mode_ff <= load_i.data[6:0];
        phy_delta_ff <= load_i.data[31:15];
      end
      if (load_i.offset == `SPVCR_OFF_PHY_TX_MARGIN_RX_EQ) begin
        tx_margin_ff <= load_i.data[15:0];
        if (UPSTREAM) begin
          rx_eq_ff <= load_i.data[23:16];
        end
      end
      if (load_i.offset == `SPVCR_OFF_SUBSYSTEM_IDENT) begin
        vendor_ident_ff <= load_i.data[15:0]; // [RULE_10]
        device_ident_ff <= load_i.data[31:16]; // [RULE_11]
      end
    end
  end

  // powerdown strap caught on the first clock after reset release; mode straps sampled every clock
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      strap_taken_ff <= 1'b0;
      refclk_pd_ff <= 1'b0;
      refclk_en_ff <= `SPVCR_RST_REFCLK_EN; // [RULE_06]
      mode_ff <= '0;
    end else begin
      strap_taken_ff <= 1'b1;
      mode_ff <= mode_straps_i; // [RULE_04]
      if (!strap_taken_ff) begin
        refclk_pd_ff <= refclk_buffer_powerdown_strap_i; // [RULE_05] [RULE_07]
      end else if (ld_ok && load_i.offset == `SPVCR_OFF_STRAP_MODE_AND_REFCLK) begin
        refclk_pd_ff <= load_i.data[20]; // [RULE_07]
        refclk_en_ff <= load_i.data[19:16]; // [RULE_07]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      refclk_global_disable_o <= 1'b0;
      refclk_output_pair_en_o <= 4'h0;
    end else begin
      refclk_global_disable_o <= refclk_pd_ff; // [RULE_05]
      refclk_output_pair_en_o <= refclk_pd_ff ? 4'h0 : refclk_en_ff; // [RULE_05] [RULE_06]
    end
  end

  // general pin control, software writable direction and value
  wire logic gpio_wr = wr_i && UPSTREAM && addr_i == `SPVCR_OFF_GENERAL_PIN_CONTROL; // [RULE_12]
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dir_ff <= 3'h0; // [RULE_14]
      outv_ff <= 3'h0;
      pin_in_ff <= 3'h0;
      gpio_out_o <= 3'h0;
      gpio_oe_o <= 3'h0;
    end else begin
      pin_in_ff <= gpio_in_i; // [RULE_13]
      if (gpio_wr) begin
        for (int i = 0; i < `SPVCR_GPIO_PINS; i++) begin
          dir_ff[i] <= wdata_i[i*`SPVCR_GPIO_STRIDE+1]; // [RULE_14]
          outv_ff[i] <= wdata_i[i*`SPVCR_GPIO_STRIDE+2]; // [RULE_15]
        end
      end
      gpio_oe_o <= dir_ff; // [RULE_15]
      gpio_out_o <= outv_ff & dir_ff; // [RULE_15]
    end
  end

  // read mux; reserved and unmapped read zero
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0; // [RULE_16]
    case (addr_i)
      `SPVCR_OFF_PHY_LANE_MODE_AND_DELTA: nxt_rdata = {phy_delta_ff, 8'h00, lane_mode_ff};
      `SPVCR_OFF_PHY_TX_MARGIN_RX_EQ: nxt_rdata = {8'h00, rx_eq_ff, tx_margin_ff};
      `SPVCR_OFF_STRAP_MODE_AND_REFCLK:
        nxt_rdata = {11'h000, refclk_pd_ff, refclk_en_ff, 7'h00, mode_ff}; // [RULE_04]
      `SPVCR_OFF_SUBSYSTEM_CAP_HEADER:
        nxt_rdata = {16'h0000, `SPVCR_CAP_NEXT, `SPVCR_CAP_ID}; // [RULE_08] [RULE_09]
      `SPVCR_OFF_SUBSYSTEM_IDENT: nxt_rdata = {device_ident_ff, vendor_ident_ff};
      `SPVCR_OFF_GENERAL_PIN_CONTROL: begin
        if (UPSTREAM) begin // [RULE_12]
          for (int i = 0; i < `SPVCR_GPIO_PINS; i++) begin
            nxt_rdata[i*`SPVCR_GPIO_STRIDE] = pin_in_ff[i]; // [RULE_13]
            nxt_rdata[i*`SPVCR_GPIO_STRIDE+1] = dir_ff[i];
            nxt_rdata[i*`SPVCR_GPIO_STRIDE+2] = outv_ff[i];
          end
        end
      end
      default: nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_o <= 32'h0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      rdata_o <= rd_i ? nxt_rdata : 32'h0;
    end
  end

  // read requests by offset; each is answered on the following edge
  sequence s_phy_read;
    rd_i && addr_i == `SPVCR_OFF_PHY_LANE_MODE_AND_DELTA;
  endsequence

  sequence s_margin_read;
    rd_i && addr_i == `SPVCR_OFF_PHY_TX_MARGIN_RX_EQ;
  endsequence

  sequence s_mode_read;
    rd_i && addr_i == `SPVCR_OFF_STRAP_MODE_AND_REFCLK;
  endsequence

  sequence s_cap_read;
    rd_i && addr_i == `SPVCR_OFF_SUBSYSTEM_CAP_HEADER;
  endsequence

  sequence s_ident_read;
    rd_i && addr_i == `SPVCR_OFF_SUBSYSTEM_IDENT;
  endsequence

  sequence s_pin_read;
    rd_i && addr_i == `SPVCR_OFF_GENERAL_PIN_CONTROL;
  endsequence

  // write lands in dir_ff, pins follow one edge later; no second write between
  sequence s_pin_write;
    gpio_wr ##1 !gpio_wr ##1 1'b1;
  endsequence

  // loader words that replace defaults
  sequence s_buf_load;
    strap_taken_ff && ld_ok && load_i.offset == `SPVCR_OFF_STRAP_MODE_AND_REFCLK;
  endsequence

  sequence s_ident_load;
    ld_ok && load_i.offset == `SPVCR_OFF_SUBSYSTEM_IDENT;
  endsequence

  // capability header
  a_cap_const: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_08]
    s_cap_read |=> rdata_o == 32'h0000c00d)
    else $error("capability header wrong");

  a_cap_next: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_09]
    s_cap_read |=> rdata_o[15:8] == 8'hc0)
    else $error("next pointer wrong");

  // phy words
  a_phy_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_02]
    s_phy_read |=> rdata_o[14:7] == 8'h00)
    else $error("phy reserved bits set");

  a_lane_read: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_01]
    s_phy_read |=> rdata_o[6:0] == $past(lane_mode_ff))
    else $error("lane mode read wrong");

  a_delta_read: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_02]
    s_phy_read |=> rdata_o[31:15] == $past(phy_delta_ff))
    else $error("delta read wrong");

  a_margin_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_03]
    s_margin_read |=> rdata_o[31:24] == 8'h00)
    else $error("margin reserved bits set");

  a_margin_read: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_03]
    s_margin_read |=> rdata_o[15:0] == $past(tx_margin_ff))
    else $error("margin read wrong");

  a_rxeq_read: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_03]
    s_margin_read |=> rdata_o[23:16] == $past(rx_eq_ff))
    else $error("equaliser read wrong");

  a_rxeq_down: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_03]
    !UPSTREAM |-> rx_eq_ff == 8'h00)
    else $error("equaliser set on downstream port");

  // mode word and clock buffer
  a_mode_zero: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_04]
    s_mode_read |=> rdata_o[15:9] == 7'h00 && rdata_o[31:21] == 11'h0)
    else $error("mode word padding set");

  a_mode_live: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_04]
    s_mode_read |=> rdata_o[8:0] == $past(mode_ff))
    else $error("mode word read wrong");

  a_strap_take: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_05]
    !strap_taken_ff |=> refclk_pd_ff == $past(refclk_buffer_powerdown_strap_i))
    else $error("powerdown strap not caught");

  a_refclk_off: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_05]
    refclk_pd_ff |=> refclk_global_disable_o && refclk_output_pair_en_o == 4'h0)
    else $error("refclk not disabled");

  a_refclk_pairs: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_06]
    !refclk_pd_ff |=> refclk_output_pair_en_o == $past(refclk_en_ff))
    else $error("refclk pair enable wrong");

  a_buf_hold: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_07]
    strap_taken_ff && !ld_ok |=> $stable(refclk_pd_ff) && $stable(refclk_en_ff))
    else $error("clock buffer changed without load");

  a_buf_load: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_07]
    s_buf_load |=> refclk_pd_ff == $past(load_i.data[20]) &&
      refclk_en_ff == $past(load_i.data[19:16]))
    else $error("clock buffer load lost");

  // subsystem identifiers
  a_ident_read: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_10]
    s_ident_read |=> rdata_o == {$past(device_ident_ff), $past(vendor_ident_ff)})
    else $error("ident read wrong");

  a_ident_load: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_10]
    s_ident_load |=> vendor_ident_ff == $past(load_i.data[15:0]))
    else $error("vendor ident load lost");

  a_devid_load: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_11]
    s_ident_load |=> device_ident_ff == $past(load_i.data[31:16]))
    else $error("device ident load lost");

  // general pins
  a_gpio_absent: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_12]
    !UPSTREAM |-> dir_ff == 3'h0 && gpio_oe_o == 3'h0)
    else $error("pin control active on downstream port");

  a_pin_sample: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_13]
    1'b1 |=> pin_in_ff == $past(gpio_in_i))
    else $error("pin level not sampled");

  a_pin_readback: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_13]
    rd_i && UPSTREAM && addr_i == `SPVCR_OFF_GENERAL_PIN_CONTROL |=>
      {rdata_o[8], rdata_o[4], rdata_o[0]} == $past(pin_in_ff))
    else $error("pin level read wrong");

  a_gpio_drive: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_14]
    s_pin_write |=> gpio_oe_o == {$past(wdata_i[9], 3), $past(wdata_i[5], 3),
      $past(wdata_i[1], 3)})
    else $error("gpio direction not applied");

  a_dir_follow: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_14]
    1'b1 |=> gpio_oe_o == $past(dir_ff))
    else $error("pin enable not following direction");

  a_gpio_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_15]
    (gpio_out_o & ~gpio_oe_o) == 3'h0)
    else $error("gpio driven while input");

  a_out_value: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_15]
    1'b1 |=> gpio_out_o == $past(outv_ff & dir_ff))
    else $error("pin value not driven");

  // reserved and read-only handling
  a_pin_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_16]
    s_pin_read |=> rdata_o[3] == 1'b0 && rdata_o[7] == 1'b0 && rdata_o[31:11] == 21'h0)
    else $error("pin reserved bits set");

  a_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_16]
    !rd_i |=> rdata_o == 32'h0 && !rvalid_o)
    else $error("read data without request");

  a_ro_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_16]
    wr_i && !ld_ok |=> $stable(vendor_ident_ff) && $stable(tx_margin_ff))
    else $error("software write changed read-only field");

  a_phy_ro: assert property (@(posedge clk_i) disable iff (!rst_n_ff) // [RULE_16]
    wr_i && !ld_ok |=> $stable(lane_mode_ff) && $stable(phy_delta_ff) &&
      $stable(device_ident_ff))
    else $error("software write changed phy field");
endmodule
`default_nettype wire

//--- rtl/spvcr_defines.svh
// offsets, field positions, reset values for the port config bank
// assumes inclusion by bare name from rtl/
`ifndef SPVCR_DEFINES_SVH
`define SPVCR_DEFINES_SVH
`define SPVCR_OFF_PHY_LANE_MODE_AND_DELTA 8'h90
`define SPVCR_OFF_PHY_TX_MARGIN_RX_EQ 8'h94
`define SPVCR_OFF_STRAP_MODE_AND_REFCLK 8'h98
`define SPVCR_OFF_SUBSYSTEM_CAP_HEADER 8'hb0
`define SPVCR_OFF_SUBSYSTEM_IDENT 8'hb4
`define SPVCR_OFF_GENERAL_PIN_CONTROL 8'hb8
`define SPVCR_RST_LANE_MODE 7'h00
`define SPVCR_RST_PHY_DELTA 17'h00001
`define SPVCR_RST_TX_MARGIN 16'h116b
`define SPVCR_RST_RX_EQ_UP 8'h86
`define SPVCR_RST_RX_EQ_DOWN 8'h00
`define SPVCR_RST_REFCLK_EN 4'hf
`define SPVCR_CAP_ID 8'h0d
`define SPVCR_CAP_NEXT 8'hc0
`define SPVCR_RST_IDENT 16'h0000
`define SPVCR_GPIO_PINS 3
`define SPVCR_GPIO_STRIDE 4
`endif

//--- rtl/spvcr_pkg.sv
// types for the port config bank
// assumes no other package
package spvcr_pkg;
  typedef struct packed {
    logic scan;
    logic [2:0] package_select_field;
    logic indicator_a;
    logic debug;
    logic fast;
    logic quiescent_current_test_n;
    logic serial_rom_skip;
  } spvcr_mode_s;
  typedef struct packed {
    logic valid;
    logic [7:0] offset;
    logic [31:0] data;
  } spvcr_load_s;
  typedef enum logic [1:0] {SPVCR_IDLE, SPVCR_LOADED} spvcr_ld_e;
endpackage

//--- tb/spvcr_regs_tb.sv
// self-checking bench for the port config register bank
// assumes the bank answers each read one cycle later on rvalid_o
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t mismatch %h vs %h", $time, a, b); end end
module spvcr_regs_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic strap = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic rvalid_o;
  spvcr_pkg::spvcr_mode_s mode_i = '0;
  spvcr_pkg::spvcr_load_s load_i = '0;
  logic [2:0] gpio_in_i = 3'h0;
  logic [2:0] gpio_out_o;
  logic [2:0] gpio_oe_o;
  logic refclk_dis;
  logic [3:0] pair_en;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic [31:0] mw;
  logic [31:0] e;
  logic [31:0] dn_rdata;
  logic [2:0] dn_oe;

  spvcr_regs #(.UPSTREAM(1'b1)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .mode_straps_i(mode_i),
    .refclk_buffer_powerdown_strap_i(strap), .rd_i(rd_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .load_i(load_i), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o),
    .gpio_oe_o(gpio_oe_o), .refclk_global_disable_o(refclk_dis),
    .refclk_output_pair_en_o(pair_en)
  );

  // downstream copy on the same inputs
  spvcr_regs #(.UPSTREAM(1'b0)) u_dut_dn (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .mode_straps_i(mode_i),
    .refclk_buffer_powerdown_strap_i(strap), .rd_i(rd_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(dn_rdata), .rvalid_o(),
    .load_i(load_i), .gpio_in_i(gpio_in_i), .gpio_out_o(),
    .gpio_oe_o(dn_oe), .refclk_global_disable_o(),
    .refclk_output_pair_en_o()
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(x);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    load_i <= '{1'b1, a, d};
    @(posedge clk_i);
    load_i.valid <= 1'b0;
  endtask

  task automatic test_done();
    if (exp_q.size() != 0) num_errors++;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // read results come back in request order
  always @(negedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) num_errors++;
      else begin
        e = exp_q.pop_front();
        `CHK(rdata_o, e)
      end
    end
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(72));
    mode_i <= 9'($urandom);
    gpio_in_i <= 3'($urandom);
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    mw = {23'h0, mode_i};
    rd(8'h90, 32'h00008000);
    rd(8'h94, 32'h0086116b);
    @(negedge clk_i);
    `CHK(dn_rdata, 32'h0000116b)
    rd(8'h98, mw | 32'h000f0000);
    `CHK({refclk_dis, pair_en}, 5'h0f)
    rd(8'hb0, 32'h0000c00d);
    rd(8'hb4, 32'h0);
    rd(8'hb8, {23'h0, gpio_in_i[2], 3'h0, gpio_in_i[1], 3'h0, gpio_in_i[0]});
    rd(8'h00, 32'h0);
    $display("test reset_values done");
    w = $urandom;
    wr(8'h90, w);
    wr(8'hb4, w);
    wr(8'h98, w);
    rd(8'h90, 32'h00008000);
    rd(8'hb4, 32'h0);
    rd(8'h98, mw | 32'h000f0000);
    $display("test readonly_writes done");
    w = $urandom;
    ld(8'hb4, w);
    rd(8'hb4, w);
    w = $urandom;
    w[20:16] = 5'h15;
    ld(8'h98, w);
    rd(8'h98, mw | 32'h00150000);
    @(negedge clk_i);
    `CHK({refclk_dis, pair_en}, 5'h10)
    w[20:16] = 5'h06;
    ld(8'h98, w);
    rd(8'h98, mw | 32'h00060000);
    @(negedge clk_i);
    `CHK({refclk_dis, pair_en}, 5'h06)
    $display("test override_loads done");
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      @(posedge clk_i);
      gpio_in_i <= 3'($urandom);
      wr(8'hb8, w);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(gpio_oe_o, {w[9], w[5], w[1]})
      `CHK(gpio_out_o, {w[10], w[6], w[2]} & {w[9], w[5], w[1]})
      `CHK(dn_oe, 3'h0)
      rd(8'hb8, {21'h0, w[10:9], gpio_in_i[2], 1'b0, w[6:5], gpio_in_i[1], 1'b0,
                 w[2:1], gpio_in_i[0]});
      @(negedge clk_i);
      `CHK(dn_rdata, 32'h0)
    end
    $display("test general_pins done");
    @(posedge clk_i);
    strap <= 1'b1;
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(8'h98, mw | 32'h001f0000);
    @(negedge clk_i);
    `CHK({refclk_dis, pair_en}, 5'h10)
    `CHK(gpio_oe_o, 3'h0)
    rd(8'hb4, 32'h0);
    $display("test strap_reset done");
    repeat (3) @(posedge clk_i);
    test_done();
  end
endmodule
`default_nettype wire
